/* File: rtl/lsc_regs.svh */
// offsets, field positions, reset value and timing counts of the first light configuration register
`ifndef LSC_REGS_SVH
`define LSC_REGS_SVH

`define LSC_CMD_CONFIG_FIRST 8'h00
`define LSC_CFG_RESET 8'h01
`define LSC_BIT_RSVD 7
`define LSC_IT_MSB 6
`define LSC_IT_LSB 4
`define LSC_BIT_MODE 3
`define LSC_BIT_TRIG 2
`define LSC_BIT_IRQ 1
`define LSC_BIT_PD 0
`define LSC_RD_IDLE 8'h00

`define LSC_CLK_PERIOD_NS 20
`define LSC_IT_BASE_NS 3125000
`define LSC_IT_CYCLES_BASE (`LSC_IT_BASE_NS / `LSC_CLK_PERIOD_NS)
`define LSC_IT_CNT_W 26

`endif

/* File: rtl/lsc_pkg.sv */
// types shared by the light configuration register logic
package lsc_pkg;
  typedef logic [2:0] lsc_it_code_t;
  typedef enum logic {LSC_MODE_AUTO, LSC_MODE_FORCED} lsc_mode_e;
  typedef enum logic {MS_IDLE, MS_RUN} lsc_meas_state_e;
endpackage

/* File: rtl/lsc_meas_timer.sv */
// integration-time timer for one measurement cycle
`include "lsc_regs.svh"
module lsc_meas_timer #(
  parameter int unsigned BASE_CYCLES = `LSC_IT_CYCLES_BASE,
  parameter int CNT_W = `LSC_IT_CNT_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic abort,
  input wire lsc_pkg::lsc_it_code_t it_sel,
  output logic busy,
  output logic done
);
  lsc_pkg::lsc_meas_state_e state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] run_len_q, run_len_d;
  lsc_pkg::lsc_it_code_t it_q, it_d;
  logic done_q, done_d;
  logic [CNT_W-1:0] len;

  // length doubles per code; base cycles are one 3.125 ms step
  assign len = CNT_W'(BASE_CYCLES) << it_sel; // R1

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    it_d = it_q;
    done_d = 1'b0;
    run_len_d = run_len_q;
    unique case (state_q)
      lsc_pkg::MS_IDLE:
      begin
        if (start && !abort)
        begin
          state_d = lsc_pkg::MS_RUN;
          cnt_d = len - CNT_W'(1); // R1
          it_d = it_sel;
          run_len_d = '0;
        end
      end
      lsc_pkg::MS_RUN:
      begin
        run_len_d = run_len_q + CNT_W'(1);
        if (abort)
          state_d = lsc_pkg::MS_IDLE;
        else if (cnt_q == '0)
        begin
          state_d = lsc_pkg::MS_IDLE;
          done_d = 1'b1;
        end
        else
          cnt_d = cnt_q - CNT_W'(1);
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= lsc_pkg::MS_IDLE;
      cnt_q <= '0;
      it_q <= '0;
      done_q <= 1'b0;
      run_len_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      it_q <= it_d;
      done_q <= done_d;
      run_len_q <= run_len_d;
    end
  end

  assign busy = (state_q == lsc_pkg::MS_RUN);
  assign done = done_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_run_length_code: assert property (done |-> run_len_q == (CNT_W'(BASE_CYCLES) << it_q)) // R1
    else $error("measurement length does not match integration code");
  a_start_runs: assert property (!busy && start && !abort |=> busy) // R2
    else $error("start did not begin a measurement");
endmodule

/* File: rtl/lsc_config_first.sv */
// first light configuration register with its measurement control
// Behaviour
// R1: bits 6:4 pick integration time 3.125 ms doubling per code to 400 ms; default 0.
// R2: in forced mode, trigger bit 2 starts one measurement; hardware clears it afterwards.
// R3: bit 1 enables the light channel interrupt; disabled by default.
// R4: bit 0 high keeps sensor shut down (default); low turns it on.
// R5: host clears both power-down halves in one configuration access.
// R6: host writes reserved bit 7 only as 0.
// R7: register holds 0x01 after power-up, sensor in shutdown.
// R8: register sits at command code 0x00, selected by an 8-bit command code.
`include "lsc_regs.svh"
module lsc_config_first #(
  parameter int unsigned IT_BASE_CYCLES = `LSC_IT_CYCLES_BASE,
  parameter int IT_CNT_W = `LSC_IT_CNT_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] cmd_code,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  output logic rd_hit,
  input wire logic power_down_high_half,
  output lsc_pkg::lsc_it_code_t integration_time_sel,
  output lsc_pkg::lsc_mode_e measure_mode_sel,
  output logic forced_measure_trigger,
  output logic channel_irq_enable,
  output logic power_down_low_half,
  output logic sensor_on,
  output logic meas_busy,
  output logic meas_done
);
  logic rst_meta_q, rst_n;
  logic [7:0] cfg_q, cfg_d;
  logic [7:0] rd_data_q, rd_data_d;
  logic rd_hit_q, rd_hit_d;
  logic wr_seen_q, wr_seen_d;
  logic wr_hit, rd_sel, meas_start, trig_set;
  lsc_pkg::lsc_mode_e mode_now;

  // reset release goes through two flops so every flop leaves reset on the same edge
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  assign wr_hit = wr_en && (cmd_code == `LSC_CMD_CONFIG_FIRST); // R8
  assign rd_sel = rd_en && (cmd_code == `LSC_CMD_CONFIG_FIRST); // R8
  assign mode_now = lsc_pkg::lsc_mode_e'(cfg_q[`LSC_BIT_MODE]);
  // a trigger only sticks when the same write leaves the block in forced mode
  assign trig_set = wr_hit && wr_data[`LSC_BIT_TRIG] && wr_data[`LSC_BIT_MODE]; // R2

  assign sensor_on = !cfg_q[`LSC_BIT_PD] && !power_down_high_half; // R4
  // done cycle is skipped so a clearing trigger cannot relaunch a measurement
  assign meas_start = sensor_on && !meas_busy && !meas_done
    && ((mode_now == lsc_pkg::LSC_MODE_AUTO) || cfg_q[`LSC_BIT_TRIG]); // R2 R4

  always_comb
  begin
    cfg_d = cfg_q;
    wr_seen_d = wr_seen_q || wr_hit;
    if (wr_hit)
    begin
      cfg_d = wr_data;
      cfg_d[`LSC_BIT_RSVD] = 1'b0;
      cfg_d[`LSC_BIT_TRIG] = 1'b0;
    end
    else if (meas_done && cfg_q[`LSC_BIT_TRIG])
      cfg_d[`LSC_BIT_TRIG] = 1'b0; // R2
    // a new trigger wins over the end-of-measurement clear
    if (trig_set)
      cfg_d[`LSC_BIT_TRIG] = 1'b1; // R2
  end

  always_comb
  begin
    rd_hit_d = rd_sel;
    rd_data_d = rd_sel ? cfg_q : `LSC_RD_IDLE; // R8
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_q <= `LSC_CFG_RESET; // R7
      wr_seen_q <= 1'b0;
      rd_data_q <= `LSC_RD_IDLE;
      rd_hit_q <= 1'b0;
    end
    else
    begin
      cfg_q <= cfg_d;
      wr_seen_q <= wr_seen_d;
      rd_data_q <= rd_data_d;
      rd_hit_q <= rd_hit_d;
    end
  end

  lsc_meas_timer #(
    .BASE_CYCLES(IT_BASE_CYCLES),
    .CNT_W(IT_CNT_W)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(meas_start),
    .abort(!sensor_on), // R4
    .it_sel(cfg_q[`LSC_IT_MSB:`LSC_IT_LSB]), // R1
    .busy(meas_busy),
    .done(meas_done)
  );

  assign rd_data = rd_data_q;
  assign rd_hit = rd_hit_q;
  assign integration_time_sel = cfg_q[`LSC_IT_MSB:`LSC_IT_LSB]; // R1
  assign measure_mode_sel = mode_now;
  assign forced_measure_trigger = cfg_q[`LSC_BIT_TRIG];
  assign channel_irq_enable = cfg_q[`LSC_BIT_IRQ]; // R3
  assign power_down_low_half = cfg_q[`LSC_BIT_PD]; // R4

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_power_up_value: assert property (!wr_seen_q |-> cfg_q == `LSC_CFG_RESET) // R7
    else $error("register left power-up value without a write");
  a_it_field_write: assert property (wr_hit |=> integration_time_sel == $past(wr_data[6:4])) // R1
    else $error("integration code not taken from write");
  a_irq_gate_write: assert property (wr_hit |=> channel_irq_enable == $past(wr_data[1])) // R3
    else $error("interrupt enable not taken from write");
  a_shutdown_no_run: assert property (power_down_low_half |-> !meas_start ##1 !meas_busy) // R4
    else $error("measurement runs while shut down");
  a_trig_self_clear: assert property (meas_done && forced_measure_trigger && !trig_set // R2
    |=> !forced_measure_trigger)
    else $error("trigger not cleared after measurement");
  a_trig_hold_pend: assert property (forced_measure_trigger && !meas_done && !wr_hit // R2
    |=> forced_measure_trigger)
    else $error("trigger dropped before measurement end");
  a_read_back_cfg: assert property (rd_sel |=> rd_hit && rd_data == $past(cfg_q)) // R8
    else $error("read of command 0x00 returned wrong value");
  a_foreign_cmd_ignored: assert property (wr_en && !wr_hit && !meas_done // R8
    |=> cfg_q == $past(cfg_q))
    else $error("write to another command code changed register");

  a_mode_field_write: assert property (wr_hit // R2
    |=> measure_mode_sel == lsc_pkg::lsc_mode_e'($past(wr_data[`LSC_BIT_MODE])))
    else $error("mode bit not taken from write");
  a_pd_field_write: assert property (wr_hit // R4
    |=> power_down_low_half == $past(wr_data[`LSC_BIT_PD]))
    else $error("power-down bit not taken from write");
  a_rsvd_kept_zero: assert property (cfg_q[`LSC_BIT_RSVD] == 1'b0) // R6
    else $error("reserved bit stored as one");
  a_trig_needs_mode: assert property (wr_hit && !wr_data[`LSC_BIT_MODE] // R2
    |=> !forced_measure_trigger)
    else $error("trigger stuck without forced mode");
  a_trig_write_sets: assert property (wr_hit && wr_data[`LSC_BIT_TRIG] && wr_data[`LSC_BIT_MODE] // R2
    |=> forced_measure_trigger)
    else $error("forced trigger write not stored");

  // outside a write the register fields other than the trigger bit must not move
  a_it_hold_idle: assert property (!wr_hit // R1
    |=> $stable(integration_time_sel))
    else $error("integration code changed without a write");
  a_irq_hold_idle: assert property (!wr_hit // R3
    |=> $stable(channel_irq_enable))
    else $error("interrupt enable changed without a write");
  a_pd_hold_idle: assert property (!wr_hit // R4
    |=> $stable(power_down_low_half))
    else $error("power-down bit changed without a write");
  a_mode_hold_idle: assert property (!wr_hit // R2
    |=> $stable(measure_mode_sel))
    else $error("mode bit changed without a write");

  a_busy_needs_on: assert property (meas_busy // R4
    |-> $past(sensor_on))
    else $error("integration running after shutdown");
  a_done_needs_on: assert property (meas_done // R4
    |-> $past(sensor_on))
    else $error("measurement finished during shutdown");
  a_done_single: assert property (meas_done // R2
    |=> !meas_done)
    else $error("measurement end pulse longer than one cycle");
  a_forced_waits_trig: assert property (!meas_busy && !forced_measure_trigger // R2
    && measure_mode_sel == lsc_pkg::LSC_MODE_FORCED |=> !meas_busy)
    else $error("forced mode measured without a trigger");
  a_forced_trig_starts: assert property (!meas_busy && !meas_done && sensor_on && forced_measure_trigger // R2
    |=> meas_busy)
    else $error("pending trigger did not start a measurement");
  a_auto_restart: assert property ((meas_done && sensor_on && measure_mode_sel == lsc_pkg::LSC_MODE_AUTO) // R2
    ##1 (sensor_on && measure_mode_sel == lsc_pkg::LSC_MODE_AUTO) |=> meas_busy)
    else $error("auto mode did not restart after a measurement");
  a_abort_keeps_trig: assert property (meas_busy && !sensor_on && forced_measure_trigger && !wr_hit // R4
    |=> !meas_busy && !meas_done && forced_measure_trigger)
    else $error("shutdown did not abort with trigger pending");
  a_rd_idle_value: assert property (!rd_sel // R8
    |=> !rd_hit && rd_data == `LSC_RD_IDLE)
    else $error("unaddressed read returned data");

  // auto mode idles at most the done cycle and the start cycle between runs
  logic [1:0] auto_idle_q, auto_idle_d;

  always_comb
  begin
    auto_idle_d = 2'h0;
    if (sensor_on && (mode_now == lsc_pkg::LSC_MODE_AUTO) && !meas_busy)
      auto_idle_d = auto_idle_q + 2'h1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      auto_idle_q <= 2'h0;
    else
      auto_idle_q <= auto_idle_d;
  end

  a_auto_gap_short: assert property (auto_idle_q != 2'h3) // R2
    else $error("auto mode stalled between measurements");
endmodule

/* File: tb/lsc_host_model.sv */
// host-side model issuing single-byte register accesses
module lsc_host_model (
  input wire logic clk,
  output logic [7:0] cmd_code,
  output logic wr_en,
  output logic [7:0] wr_data,
  output logic rd_en,
  input wire logic [7:0] rd_data,
  input wire logic rd_hit
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    cmd_code = 8'hFF;
    wr_data = 8'hFF;
    wr_en = 1'h0;
    rd_en = 1'h0;
  end
  // released lines are inverted so nothing leans on a stale byte
  task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
    @(negedge clk);
    cmd_code = cmd;
    wr_data = data;
    wr_en = 1'h1;
    @(negedge clk);
    wr_en = 1'h0;
    cmd_code = ~cmd;
    wr_data = ~data;
  endtask
  task automatic rd(input logic [7:0] cmd, output logic [7:0] data, output logic hit);
    @(negedge clk);
    cmd_code = cmd;
    rd_en = 1'h1;
    @(negedge clk);
    data = rd_data;
    hit = rd_hit;
    rd_en = 1'h0;
    cmd_code = ~cmd;
  endtask
endmodule

/* File: tb/tb_lsc_config_first.sv */
// self-checking bench for the first light configuration register
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_lsc_config_first;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic pd_high = 1'h1;
  logic [7:0] cmd_code, wr_data, rd_data, d;
  logic wr_en, rd_en, rd_hit, h, trig, irq, pd_low, sensor_on, busy, done;
  lsc_pkg::lsc_it_code_t it_sel;
  lsc_pkg::lsc_mode_e mode;
  int n_fail = 0;
  int total_checks = 0;
  always #10 clk = ~clk;
  lsc_host_model host (.clk(clk), .cmd_code(cmd_code), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en),
    .rd_data(rd_data), .rd_hit(rd_hit));
  // short base count keeps code 1 at 8 cycles
  lsc_config_first #(.IT_BASE_CYCLES(4)) dut (.clk(clk), .resetn(resetn), .cmd_code(cmd_code), .wr_en(wr_en),
    .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data), .rd_hit(rd_hit), .power_down_high_half(pd_high),
    .integration_time_sel(it_sel), .measure_mode_sel(mode), .forced_measure_trigger(trig),
    .channel_irq_enable(irq), .power_down_low_half(pd_low), .sensor_on(sensor_on), .meas_busy(busy),
    .meas_done(done));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_reset();
    host.rd(8'h00, d, h);
    `CHK(d, 8'h01)
    `CHK(h, 1'h1)
    `CHK(sensor_on, 1'h0)
    host.rd(8'h01, d, h);
    `CHK(d, 8'h00)
    `CHK(h, 1'h0)
    $display("test reset done");
  endtask
  task automatic t_fields();
    // trigger without forced mode in the same byte must not stick
    host.wr(8'h00, 8'h76);
    `CHK(it_sel, 3'h7)
    `CHK(irq, 1'h1)
    `CHK(pd_low, 1'h0)
    `CHK(sensor_on, 1'h0)
    `CHK(mode, lsc_pkg::LSC_MODE_AUTO)
    host.rd(8'h00, d, h);
    `CHK(d, 8'h72)
    host.wr(8'h05, 8'h00);
    host.rd(8'h00, d, h);
    `CHK(d, 8'h72)
    $display("test fields done");
  endtask
  task automatic t_forced();
    int n;
    int k;
    n = 0;
    host.wr(8'h00, 8'h01);
    pd_high = 1'h0;
    host.wr(8'h00, 8'h1C);
    `CHK(sensor_on, 1'h1)
    `CHK(trig, 1'h1)
    `CHK(mode, lsc_pkg::LSC_MODE_FORCED)
    for (k = 0; k < 1000 && done !== 1'h1; k++)
    begin
      @(negedge clk);
      if (busy === 1'h1)
        n++;
    end
    `CHK(n, 8)
    `CHK(done, 1'h1)
    @(negedge clk);
    `CHK(trig, 1'h0)
    repeat (20) @(negedge clk);
    `CHK(busy, 1'h0)
    host.wr(8'h00, 8'h01);
    `CHK(sensor_on, 1'h0)
    $display("test forced done");
  endtask
  task automatic t_auto_abort();
    int n;
    int k;
    n = 0;
    // auto mode at code 0 measures back to back
    host.wr(8'h00, 8'h00);
    `CHK(mode, lsc_pkg::LSC_MODE_AUTO)
    `CHK(sensor_on, 1'h1)
    for (k = 0; k < 100 && done !== 1'h1; k++)
    begin
      @(negedge clk);
      if (busy === 1'h1)
        n++;
    end
    `CHK(n, 4)
    @(negedge clk);
    `CHK(busy, 1'h0)
    @(negedge clk);
    `CHK(busy, 1'h1)
    host.wr(8'h00, 8'h01);
    @(negedge clk);
    `CHK(busy, 1'h0)
    // shutdown mid-measurement aborts it and keeps the trigger pending
    host.wr(8'h00, 8'h1C);
    repeat (3) @(negedge clk);
    `CHK(busy, 1'h1)
    pd_high = 1'h1;
    @(negedge clk);
    `CHK(busy, 1'h0)
    `CHK(done, 1'h0)
    `CHK(trig, 1'h1)
    pd_high = 1'h0;
    n = 0;
    for (k = 0; k < 100 && done !== 1'h1; k++)
    begin
      @(negedge clk);
      if (busy === 1'h1)
        n++;
    end
    `CHK(n, 8)
    @(negedge clk);
    `CHK(trig, 1'h0)
    host.wr(8'h00, 8'h01);
    `CHK(pd_low, 1'h1)
    $display("test auto abort done");
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    resetn = 1'h1;
    repeat (3) @(posedge clk);
    t_reset();
    t_fields();
    t_forced();
    t_auto_abort();
    tally_and_finish();
  end
  // all tests need about a hundred cycles
  initial
  begin
    #100us;
    n_fail++;
    tally_and_finish();
  end
endmodule
